// >>> pkg/scaling_pkg.sv
// holds constants shared by the voltage scaling setup register block
// assumes a pmbus command decoder presents decoded byte-level accesses
// Notes on behaviour
// - bit 7 set selects scaling mode, clear selects plain pmbus mode.
// - in scaling mode the related scaling registers ignore writes.
// - a blocked address, dac default or ext write sets the misc fault flag and raises alert.
// - in scaling mode trim and margin step commands are nacked both ways.
// - a new mode bit acts only after store and power cycle.
// - bit 5 picks pin threshold, 0 is 2.5 V, 1 is 1.8 V.
// - pin level bit exists on page 0 only; page 1 reads zero.
// - startup bit 4 acts only while the channel is in scaling mode.
// - in scaling mode the startup bit switches sub-mode at once.
// - in startup sub-mode reference comes from the dac default register.
// - during soft start in sub-mode slew follows soft start rise time.
// - after soft start in sub-mode slew follows the slew select bit.
// - in startup sub-mode dac default register writes are accepted.
// - in startup sub-mode serial scaling bus commands are ignored.
// - unimplemented bits read zero and discard written values.
// - double commit bit set needs each commit received twice.
// - payload field 01 10-bit, 10 12-bit, 11 16-bit, 00 reserved.
// - slew select 0 is 200 mV per 30 us, 1 is 2 mV per 30 us.
// - clearing startup bit with mode bit set returns to plain scaling.
package scaling_pkg;
	localparam logic [7:0]  setup_cmd       = 8'he9;
	localparam logic [7:0]  address_cmd     = 8'hea;
	localparam logic [7:0]  dac_default_cmd = 8'heb;
	localparam logic [7:0]  ext_a_cmd       = 8'hec;
	localparam logic [7:0]  ext_b_cmd       = 8'hed;
	localparam logic [7:0]  trim_cmd        = 8'hd4;
	localparam logic [7:0]  margin_high_cmd = 8'hd5;
	localparam logic [7:0]  margin_low_cmd  = 8'hd6;
	localparam logic [15:0] setup_reset     = 16'h0002;
	localparam int          mode_bit        = 7;
	localparam int          level_bit       = 5;
	localparam int          startup_bit     = 4;
	localparam int          double_bit      = 3;
	localparam int          payload_lo      = 1;
	localparam int          slew_bit        = 0;
	localparam logic [15:0] impl_mask       = 16'h00bf;
	localparam logic [15:0] page1_mask      = 16'h009f;
	localparam logic [1:0]  payload_10      = 2'h1;
	localparam logic [1:0]  payload_12      = 2'h2;
	localparam logic [1:0]  payload_16      = 2'h3;
	localparam logic [4:0]  width_10        = 5'h0a;
	localparam logic [4:0]  width_12        = 5'h0c;
	localparam logic [4:0]  width_16        = 5'h10;
	localparam logic [7:0]  fast_step_mv    = 8'hc8;
	localparam logic [7:0]  slow_step_mv    = 8'h02;
	localparam int          step_time_us    = 30;
	localparam int          clock_mhz       = 25;
	localparam int          step_cycles     = step_time_us * clock_mhz;
endpackage

// >>> design/channel_mode.sv
// one channel's operating mode decode from the latched enable and setup bits
// assumes mode_latched only changes at power-up
`timescale 1ns/10ps
module channel_mode (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic mode_latched,
	input  wire logic startup_bit,
	input  wire logic soft_start_done,
	output logic      in_scaling,
	output logic      in_startup,
	output logic      slew_from_rise
);
	typedef enum logic [2:0] {
		pmbus_s   = 3'b001,
		scaling_s = 3'b010,
		preset_s  = 3'b100
	} mode_t;
	typedef struct packed {
		mode_t mode;
	} state_t;
	state_t st_reg;
	state_t st_next;

	always_comb begin
		st_next = st_reg;
		unique case (st_reg.mode)
			pmbus_s: begin
				if (mode_latched)
					st_next.mode = startup_bit ? preset_s : scaling_s;
			end
			scaling_s: begin
				if (!mode_latched)
					st_next.mode = pmbus_s;
				else if (startup_bit)
					st_next.mode = preset_s;
			end
			preset_s: begin
				if (!mode_latched)
					st_next.mode = pmbus_s;
				else if (!startup_bit)
					st_next.mode = scaling_s;
			end
			default: st_next.mode = pmbus_s;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset)
			st_reg <= '{mode: pmbus_s};
		else
			st_reg <= st_next;
	end

	// startup bit is ignored in pmbus mode
	assign in_scaling     = st_reg.mode != pmbus_s;
	assign in_startup     = st_reg.mode == preset_s;
	assign slew_from_rise = in_startup && !soft_start_done;
endmodule // channel_mode

// >>> design/voltage_scaling_setup.sv
// setup register bank for two paged channels with mode-based protection
// assumes a decoder gives one-cycle write and read strobes with page select
`timescale 1ns/10ps
module voltage_scaling_setup (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        power_up,
	input  wire logic [1:0]  stored_mode,
	input  wire logic        page,
	input  wire logic [7:0]  cmd,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  soft_start_done,
	input  wire logic        serial_cmd_valid,
	input  wire logic        serial_commit,
	input  wire logic        serial_channel,
	output logic [15:0]      rd_data,
	output logic             access_nack,
	output logic             write_allow,
	output logic             misc_fault_set,
	output logic             alert_set,
	output logic             pin_level_select,
	output logic [1:0]       scaling_mode,
	output logic [1:0]       preset_reference_mode,
	output logic [1:0]       slew_from_rise,
	output logic [1:0]       slow_slew,
	output logic [4:0]       payload_width_ch0,
	output logic [4:0]       payload_width_ch1,
	output logic             serial_accept,
	output logic             commit_apply
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [15:0] setup0;
		logic [15:0] setup1;
		logic [1:0]  mode_latch;
		logic [1:0]  commit_seen;
		logic [15:0] rd;
		logic        nack;
		logic        fault;
		logic        commit;
	} state_t;
	state_t st_reg;
	state_t st_next;

	logic [1:0] in_scaling;
	logic [1:0] in_startup;
	logic       prot_cmd;
	logic       gated_cmd;
	logic       cur_scaling;
	logic       cur_startup;
	logic [15:0] cur_setup;
	logic       ch_double;

	assign cur_scaling = in_scaling[page];
	assign cur_startup = in_startup[page];
	assign cur_setup   = page ? st_reg.setup1 : st_reg.setup0;

	// ==========================================================
	// command decode
	// dac default stays writable while the channel is in startup sub-mode
	always_comb begin
		prot_cmd  = 1'b0;
		gated_cmd = 1'b0;
		unique case (cmd)
			scaling_pkg::address_cmd,
			scaling_pkg::ext_a_cmd,
			scaling_pkg::ext_b_cmd: begin
				prot_cmd = 1'b1;
			end
			scaling_pkg::dac_default_cmd: begin
				prot_cmd = !cur_startup;
			end
			scaling_pkg::trim_cmd,
			scaling_pkg::margin_high_cmd,
			scaling_pkg::margin_low_cmd: begin
				gated_cmd = 1'b1;
			end
			default: begin
				prot_cmd  = 1'b0;
				gated_cmd = 1'b0;
			end
		endcase
	end

	assign ch_double   = serial_channel ? st_reg.setup1[scaling_pkg::double_bit]
		: st_reg.setup0[scaling_pkg::double_bit];

	// ==========================================================
	// per channel mode decode
	channel_mode u_mode0 (
		.mclk            (mclk),
		.reset           (reset),
		.mode_latched    (st_reg.mode_latch[0]),
		.startup_bit     (st_reg.setup0[scaling_pkg::startup_bit]),
		.soft_start_done (soft_start_done[0]),
		.in_scaling      (in_scaling[0]),
		.in_startup      (in_startup[0]),
		.slew_from_rise  (slew_from_rise[0])
	);
	channel_mode u_mode1 (
		.mclk            (mclk),
		.reset           (reset),
		.mode_latched    (st_reg.mode_latch[1]),
		.startup_bit     (st_reg.setup1[scaling_pkg::startup_bit]),
		.soft_start_done (soft_start_done[1]),
		.in_scaling      (in_scaling[1]),
		.in_startup      (in_startup[1]),
		.slew_from_rise  (slew_from_rise[1])
	);

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.nack = 1'b0;
		st_next.fault = 1'b0;
		st_next.commit = 1'b0;
		if (power_up)
			st_next.mode_latch = stored_mode;
		if (wr_stb && cmd == scaling_pkg::setup_cmd) begin
			if (page)
				st_next.setup1 = wr_data & scaling_pkg::page1_mask;
			else
				st_next.setup0 = wr_data & scaling_pkg::impl_mask;
		end
		if (wr_stb && prot_cmd && cur_scaling)
			st_next.fault = 1'b1;
		if ((wr_stb || rd_stb) && gated_cmd && cur_scaling)
			st_next.nack = 1'b1;
		if (rd_stb)
			st_next.rd = (cmd == scaling_pkg::setup_cmd) ? cur_setup : 16'h0000;
		if (serial_accept && serial_commit) begin
			if (!ch_double || st_reg.commit_seen[serial_channel]) begin
				st_next.commit = 1'b1;
				st_next.commit_seen[serial_channel] = 1'b0;
			end else begin
				st_next.commit_seen[serial_channel] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			st_reg <= '{setup0: scaling_pkg::setup_reset,
				setup1: scaling_pkg::setup_reset, default: '0};
		else
			st_reg <= st_next;
	end

	// ==========================================================
	// payload width decode
	function automatic logic [4:0] width_of(input logic [1:0] p);
		unique case (p)
			scaling_pkg::payload_12: width_of = scaling_pkg::width_12;
			scaling_pkg::payload_16: width_of = scaling_pkg::width_16;
			default: width_of = scaling_pkg::width_10; // reserved maps to 10
		endcase
	endfunction

	// ==========================================================
	// outputs
	assign rd_data               = st_reg.rd;
	assign access_nack           = st_reg.nack;
	assign misc_fault_set        = st_reg.fault;
	assign alert_set             = st_reg.fault;
	// protected writes never land while the channel is in scaling mode
	assign write_allow           = wr_stb && !(prot_cmd && cur_scaling)
		&& !(gated_cmd && cur_scaling);
	assign pin_level_select      = st_reg.setup0[scaling_pkg::level_bit];
	assign scaling_mode          = in_scaling;
	assign preset_reference_mode = in_startup;
	assign slow_slew = {st_reg.setup1[scaling_pkg::slew_bit],
		st_reg.setup0[scaling_pkg::slew_bit]};
	assign payload_width_ch0 =
		width_of(st_reg.setup0[scaling_pkg::payload_lo +: 2]);
	assign payload_width_ch1 =
		width_of(st_reg.setup1[scaling_pkg::payload_lo +: 2]);
	assign serial_accept = serial_cmd_valid && in_scaling[serial_channel]
		&& !in_startup[serial_channel];
	assign commit_apply  = st_reg.commit;
endmodule // voltage_scaling_setup

// >>> sim/voltage_scaling_setup_asserts.sv
// port checks for the scaling setup register bank
// assumes a bind onto every voltage_scaling_setup instance
`timescale 1ns/10ps
module voltage_scaling_setup_asserts (
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        power_up,
	input wire logic        page,
	input wire logic [7:0]  cmd,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [1:0]  soft_start_done,
	input wire logic        serial_cmd_valid,
	input wire logic        serial_channel,
	input wire logic [15:0] rd_data,
	input wire logic        access_nack,
	input wire logic        write_allow,
	input wire logic        misc_fault_set,
	input wire logic        alert_set,
	input wire logic [1:0]  scaling_mode,
	input wire logic [1:0]  preset_reference_mode,
	input wire logic [1:0]  slew_from_rise,
	input wire logic        serial_accept
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_trim;
		(rd_stb || wr_stb) && cmd inside {8'hd4, 8'hd5, 8'hd6};
	endsequence
	sequence s_prot;
		wr_stb && scaling_mode[page] && cmd inside {8'hea, 8'hec, 8'hed};
	endsequence
	a_trim_nack: assert property (
		s_trim ##0 scaling_mode[page] |=> access_nack)
		else $error("trim access not refused");
	a_nack_cause: assert property (
		access_nack |-> $past(rd_stb) || $past(wr_stb))
		else $error("refusal without access");
	a_prot_block: assert property (
		s_prot |-> !write_allow ##1 (misc_fault_set && alert_set))
		else $error("protected write not blocked");
	a_fault_cause: assert property (
		misc_fault_set |-> $past(wr_stb) && !$past(write_allow))
		else $error("fault without blocked write");
	a_mode_power: assert property (
		$changed(scaling_mode) |-> $past(power_up, 2))
		else $error("mode changed without power up");
	a_startup_gate: assert property (
		(preset_reference_mode & ~scaling_mode) == 2'h0)
		else $error("startup outside scaling mode");
	a_rise_slew: assert property (
		slew_from_rise == (preset_reference_mode & ~soft_start_done))
		else $error("slew source wrong");
	a_serial_quiet: assert property (
		serial_accept |-> serial_cmd_valid
			&& !preset_reference_mode[serial_channel])
		else $error("serial command taken in startup");
	a_page_one: assert property (
		rd_stb && page && cmd == 8'he9
			|=> (rd_data & 16'hff60) == 16'h0000)
		else $error("page one read shows dropped bits");
	a_spare_bits: assert property (
		(rd_data & 16'hff40) == 16'h0000)
		else $error("read shows unimplemented bits");
endmodule // voltage_scaling_setup_asserts
bind voltage_scaling_setup voltage_scaling_setup_asserts chk (.*);

// >>> sim/scaling_master_model.sv
// serial scaling master issuing one commit frame per request
// assumes requests arrive just after a rising mclk edge
`timescale 1ns/10ps
module scaling_master_model (
	input  wire logic mclk,
	input  wire logic go,
	input  wire logic chan,
	output logic      serial_cmd_valid,
	output logic      serial_commit,
	output logic      serial_channel
);
	logic last_reg = 1'h0;
	always_ff @(posedge mclk) if (go) last_reg <= chan;
	// the released channel line shows the inverse of the last channel; valid and commit drop low
	assign serial_cmd_valid = go;
	assign serial_commit = go;
	assign serial_channel = go ? chan : ~last_reg;
endmodule // scaling_master_model

// >>> sim/voltage_scaling_setup_tb.sv
// self-checking bench for the scaling setup register bank
// assumes the checker bind and the serial master model are compiled
`timescale 1ns/10ps
module voltage_scaling_setup_tb;
	logic mclk = 0, reset = 1, power_up = 0, page = 0, wr_stb = 0, rd_stb = 0;
	logic go = 0, chan = 0, serial_cmd_valid, serial_commit, serial_channel;
	logic [1:0] stored_mode = 2'h3, soft_start_done = 2'h0;
	logic [7:0] cmd = 8'h00;
	logic [15:0] wr_data = 16'h0000, rd_data, d, v, msk;
	logic access_nack, write_allow, misc_fault_set, alert_set;
	logic pin_level_select, serial_accept, commit_apply, w, k, f, p, al;
	logic [1:0] scaling_mode, preset_reference_mode, slew_from_rise, slow_slew;
	logic [4:0] payload_width_ch0, payload_width_ch1, ws;
	int failures = 0, samples_checked = 0;
	always #20 mclk = ~mclk;
	voltage_scaling_setup dut (.*);
	scaling_master_model m (.*);
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic flag(string n, logic e, logic g);
		chk(n, {15'h0, e}, {15'h0, g});
	endtask
	function automatic logic [4:0] pw(logic [1:0] x);
		return x == scaling_pkg::payload_12 ? scaling_pkg::width_12 :
			x == scaling_pkg::payload_16 ? scaling_pkg::width_16 :
			scaling_pkg::width_10;
	endfunction
	task automatic acc(logic wr, logic pg, logic [7:0] c, logic [15:0] x);
		@(posedge mclk);
		#1;
		wr_stb = wr;
		rd_stb = !wr;
		page = pg;
		cmd = c;
		wr_data = x;
		#1;
		w = write_allow;
		@(posedge mclk);
		#1;
		wr_stb = 0;
		rd_stb = 0;
		k = access_nack;
		f = misc_fault_set;
		al = alert_set;
		d = rd_data;
	endtask
	task automatic ser(logic ch);
		@(posedge mclk);
		#1;
		go = 1;
		chan = ch;
		#1;
		k = serial_accept;
		@(posedge mclk);
		#1;
		go = 0;
		f = commit_apply;
	endtask
	task automatic settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic close_out;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		close_out();
	end
	initial begin
		v = $urandom(41823);
		repeat (8) @(posedge mclk);
		#1;
		reset = 0;
		acc(0, 0, scaling_pkg::setup_cmd, 0);
		chk("setup reset", scaling_pkg::setup_reset, d);
		for (int i = 0; i < 12; i++) begin
			v = $urandom;
			p = i[1];
			acc(1, p, scaling_pkg::setup_cmd, v);
			acc(0, p, scaling_pkg::setup_cmd, 0);
			msk = p ? scaling_pkg::page1_mask : scaling_pkg::impl_mask;
			ws = p ? payload_width_ch1 : payload_width_ch0;
			chk("setup", v & msk, d);
			chk("width", 16'(pw(v[2:1])), 16'(ws));
			flag("slow", v[0], slow_slew[p]);
			if (!p) flag("level", v[5], pin_level_select);
			flag("no switch", 0, scaling_mode[p]);
			flag("no startup", 0, preset_reference_mode[p]);
		end
		acc(0, 0, scaling_pkg::trim_cmd, 0);
		flag("nack pmbus", 0, k);
		acc(1, 0, scaling_pkg::setup_cmd, 16'h0080);
		acc(1, 1, scaling_pkg::setup_cmd, 16'h0088);
		power_up = 1;
		settle();
		power_up = 0;
		settle();
		chk("modes", 16'h0003, 16'(scaling_mode));
		for (int c = 8'hd4; c <= 8'hd6; c++) begin
			acc(c[0], 0, 8'(c), 0);
			flag("nack", 1, k);
		end
		acc(1, 1, scaling_pkg::address_cmd, 16'h0001);
		flag("addr allow", 0, w);
		flag("fault", 1, f);
		flag("alert", 1, al);
		acc(1, 0, scaling_pkg::dac_default_cmd, 16'h0001);
		flag("dac blocked", 0, w);
		ser(0);
		flag("single commit", 1, f);
		ser(1);
		flag("first commit", 0, f);
		ser(1);
		flag("second commit", 1, f);
		acc(1, 0, scaling_pkg::setup_cmd, 16'h0090);
		settle();
		flag("startup", 1, preset_reference_mode[0]);
		flag("rise", 1, slew_from_rise[0]);
		soft_start_done = 2'h3;
		#1;
		flag("select", 0, slew_from_rise[0]);
		acc(1, 0, scaling_pkg::dac_default_cmd, 16'h01f4);
		flag("dac open", 1, w);
		ser(0);
		flag("ignored", 0, k);
		acc(1, 0, scaling_pkg::setup_cmd, 16'h0080);
		settle();
		flag("back", 0, preset_reference_mode[0]);
		stored_mode = 2'h1;
		power_up = 1;
		settle();
		power_up = 0;
		settle();
		chk("modes ch0", 16'h0001, 16'(scaling_mode));
		acc(1, 1, scaling_pkg::address_cmd, 16'h0001);
		flag("addr open", 1, w);
		flag("no fault", 0, f);
		acc(0, 1, scaling_pkg::trim_cmd, 0);
		flag("nack off", 0, k);
		close_out();
	end
endmodule // voltage_scaling_setup_tb
